//--- common/lfdt_defs.svh
// constants for the local flowthrough transfer engine
// assumes inclusion by bare name from the package only; the design modules use its macros without including it
`ifndef LFDT_DEFS_SVH
`define LFDT_DEFS_SVH
`define LFDT_ADDR_W 16
`define LFDT_DATA_W 16
`define LFDT_CNT_W 16
`define LFDT_NCHAN 2
`define LFDT_NPORT 4
`define LFDT_NDREQ 3
`define LFDT_DREQ_NONE 2'h0
`define LFDT_STEP_WORD 16'h0002
`define LFDT_STEP_BYTE 16'h0001
`define LFDT_STEP_NONE 16'h0000
`define LFDT_BE_NONE 2'h0
`define LFDT_BE_WORD 2'h3
`define LFDT_BE_LO 2'h1
`define LFDT_BE_HI 2'h2
`define LFDT_CNT_LAST 16'h0001
`define LFDT_MODE_STANDALONE 1'b0
`endif

//--- common/lfdt_pkg.sv
// types and helpers shared by the transfer engine modules
// assumes lfdt_defs.svh is on the include path
package lfdt_pkg;
`include "lfdt_defs.svh"

  // gray codes along idle, arbitrate, read, write
  typedef enum logic [1:0] {
    LFDT_IDLE = 2'h0,
    LFDT_ARB = 2'h1,
    LFDT_READ = 2'h3,
    LFDT_WRITE = 2'h2
  } lfdt_state_type;

  typedef struct packed {
    logic byte_mode;
    logic burst;
    logic src_inc;
    logic dst_inc;
    logic [1:0] dreq_sel;
  } lfdt_cfg_type;

  typedef struct packed {
    logic [`LFDT_ADDR_W-1:0] src;
    logic [`LFDT_ADDR_W-1:0] dst;
    logic [`LFDT_CNT_W-1:0] cnt;
    lfdt_cfg_type cfg;
  } lfdt_setup_type;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [1:0] be;
    logic [`LFDT_ADDR_W-1:0] addr;
    logic [`LFDT_DATA_W-1:0] wdata;
  } lfdt_bus_type;

  // next address after one unit, by byte or word step
  function automatic logic [`LFDT_ADDR_W-1:0] lfdt_adv(
    input logic [`LFDT_ADDR_W-1:0] addr, input logic inc, input logic byte_mode);
    logic [`LFDT_ADDR_W-1:0] step;
    step = !inc ? `LFDT_STEP_NONE : (byte_mode ? `LFDT_STEP_BYTE : `LFDT_STEP_WORD);
    return addr + step;
  endfunction

  // byte lanes for one access
  function automatic logic [1:0] lfdt_lane(input logic a0, input logic byte_mode);
    return !byte_mode ? `LFDT_BE_WORD : (a0 ? `LFDT_BE_HI : `LFDT_BE_LO);
  endfunction
endpackage

//--- rtl/lfdt_chan.sv
// one transfer channel: addresses, unit count and run state
// assumes the top only steps an active channel and owns the bus cycles
`timescale 1ns/1ps
module lfdt_chan
  import lfdt_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic i_start,
  input wire lfdt_setup_type i_setup,
  input wire logic i_step,
  output logic o_active,
  output logic o_done,
  output lfdt_setup_type o_setup
);

  logic last_unit;
  assign last_unit = (o_setup.cnt == `LFDT_CNT_LAST);

  ////////////////////////////////////////////////////////////////////
  // load on start, advance per completed pair; a count of zero means 65536
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_active <= 1'b0;
      o_done <= 1'b0;
      o_setup <= '0;
    end else begin
      o_done <= 1'b0;
      if (i_start && !o_active) begin
        o_setup <= i_setup;
        o_active <= 1'b1;
      end else if (i_step && o_active) begin
        o_setup.src <= lfdt_adv(o_setup.src, o_setup.cfg.src_inc, o_setup.cfg.byte_mode);
        o_setup.dst <= lfdt_adv(o_setup.dst, o_setup.cfg.dst_inc, o_setup.cfg.byte_mode);
        o_setup.cnt <= o_setup.cnt - `LFDT_CNT_LAST;
        if (last_unit) begin
          o_active <= 1'b0;
          o_done <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  property p_chan_stop;
    @(posedge i_core_clk) disable iff (!i_rstn)
      (i_step && o_active && last_unit) |=> (!o_active && o_done) ##1 !o_done;
  endproperty
  a_chan_stop: assert property (p_chan_stop) else $error("channel did not stop at zero");

  property p_chan_dec;
    @(posedge i_core_clk) disable iff (!i_rstn)
      (i_step && o_active && !last_unit) |=>
        (o_active && o_setup.cnt == $past(o_setup.cnt) - `LFDT_CNT_LAST);
  endproperty
  a_chan_dec: assert property (p_chan_dec) else $error("count not decremented once");

  c_chan_done: cover property (@(posedge i_core_clk) disable iff (!i_rstn) o_done);
endmodule

//--- rtl/lfdt_top.sv
// two-channel flowthrough transfer engine on the local 16-bit bus
// assumes a local arbiter granting the bus and a one-clock-or-longer cycle ended by ack
// Summary of operation
// - two independent channels, each moving up to 64K units per operation
// - source and destination are 16-bit local bus addresses
// - serial and parallel port requests can pace each channel
// - bus shared between channels and processor; bursts keep the bus
// - every unit is a source read then a destination write
// - read data sits in a holding register until written
// - the write is issued in the bus cycle right after the read
// - memory and i/o addresses are handled alike as source or destination
// - standalone: backplane transceivers off, backplane selects ignored
// - standalone: processor references to system bus space are aborted
// - transfers work on full words or single bytes
// - the id switch chooses standalone or peripheral processor mode
// - each port receiving data raises an interrupt request
// - pending port requests are served lowest port number first
`timescale 1ns/1ps
module lfdt_top
  import lfdt_pkg::*;
#(
  parameter int NPORT = `LFDT_NPORT
)(
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic i_id_switch,
  input wire logic [`LFDT_NCHAN-1:0] i_start,
  input wire lfdt_setup_type i_setup0,
  input wire lfdt_setup_type i_setup1,
  input wire logic i_pri_ch1,
  input wire logic [`LFDT_NDREQ-1:0] i_port_dreq,
  input wire logic i_bus_grant,
  input wire logic i_bus_ack,
  input wire logic [`LFDT_DATA_W-1:0] i_bus_rdata,
  output logic o_bus_req,
  output lfdt_bus_type o_bus,
  output logic [`LFDT_NCHAN-1:0] o_busy,
  output logic [`LFDT_NCHAN-1:0] o_done,
  input wire logic i_cpu_sys_ref,
  output logic o_cpu_abort,
  input wire logic i_bp_sel,
  output logic o_bp_local_hit,
  output logic o_xcvr_en,
  input wire logic [NPORT-1:0] i_port_rx,
  input wire logic i_irq_ack,
  output logic o_irq_req,
  output logic [$clog2(NPORT)-1:0] o_irq_id
);

  if (NPORT < 2 || NPORT > 8) begin : g_chk
    $error("NPORT must lie between 2 and 8");
  end

  ////////////////////////////////////////////////////////////////////
  // pin synchroniser: id switch, backplane select, port requests
  localparam int NSYNC = `LFDT_NDREQ + 2;
  logic [NSYNC-1:0] meta_reg;
  logic [NSYNC-1:0] sync_reg;
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= {i_port_dreq, i_bp_sel, i_id_switch};
      sync_reg <= meta_reg;
    end
  end

  logic id_s;
  logic bp_sel_s;
  logic [`LFDT_NDREQ-1:0] dreq_s;
  logic standalone;
  assign id_s = sync_reg[0];
  assign bp_sel_s = sync_reg[1];
  assign dreq_s = sync_reg[NSYNC-1:2];
  assign standalone = (id_s == `LFDT_MODE_STANDALONE);

  ////////////////////////////////////////////////////////////////////
  // mode-dependent backplane isolation and abort of system references
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_xcvr_en <= 1'b0;
      o_bp_local_hit <= 1'b0;
      o_cpu_abort <= 1'b0;
    end else begin
      o_xcvr_en <= !standalone;
      o_bp_local_hit <= !standalone && bp_sel_s;
      o_cpu_abort <= standalone && i_cpu_sys_ref;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // channels
  lfdt_setup_type ch_setup [`LFDT_NCHAN];
  logic [`LFDT_NCHAN-1:0] ch_step;
  lfdt_chan u_ch0 (
    .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_start(i_start[0]), .i_setup(i_setup0),
    .i_step(ch_step[0]), .o_active(o_busy[0]), .o_done(o_done[0]), .o_setup(ch_setup[0])
  );
  lfdt_chan u_ch1 (
    .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_start(i_start[1]), .i_setup(i_setup1),
    .i_step(ch_step[1]), .o_active(o_busy[1]), .o_done(o_done[1]), .o_setup(ch_setup[1])
  );

  // a paced channel only runs while its selected port request is high;
  // sync delay means the peripheral must drop its request early enough
  function automatic logic paced_ok(input lfdt_cfg_type cfg, input logic [`LFDT_NDREQ-1:0] dq);
    logic [1:0] idx;
    idx = cfg.dreq_sel - 2'h1;
    return (cfg.dreq_sel == `LFDT_DREQ_NONE) || dq[idx];
  endfunction

  logic [`LFDT_NCHAN-1:0] elig;
  logic pick1;
  logic any_elig;
  assign elig[0] = o_busy[0] && paced_ok(ch_setup[0].cfg, dreq_s);
  assign elig[1] = o_busy[1] && paced_ok(ch_setup[1].cfg, dreq_s);
  assign any_elig = |elig;
  assign pick1 = elig[1] && (!elig[0] || i_pri_ch1);

  ////////////////////////////////////////////////////////////////////
  // transfer sequencer
  lfdt_state_type state_reg;
  lfdt_state_type state_next;
  logic cur_reg;
  logic [`LFDT_DATA_W-1:0] hold_reg;
  lfdt_setup_type cur_setup;
  logic keep_bus;
  logic [7:0] rd_byte;
  assign cur_setup = ch_setup[cur_reg];
  assign rd_byte = cur_setup.src[0] ? i_bus_rdata[15:8] : i_bus_rdata[7:0];
  // burst keeps the bus only if this channel still has units and is still paced
  assign keep_bus = cur_setup.cfg.burst && cur_setup.cnt != `LFDT_CNT_LAST
    && paced_ok(cur_setup.cfg, dreq_s);
  assign ch_step[0] = (state_reg == LFDT_WRITE) && i_bus_ack && !cur_reg;
  assign ch_step[1] = (state_reg == LFDT_WRITE) && i_bus_ack && cur_reg;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      LFDT_IDLE: if (any_elig) state_next = LFDT_ARB;
      LFDT_ARB: begin
        if (!any_elig) state_next = LFDT_IDLE;
        else if (i_bus_grant) state_next = LFDT_READ;
      end
      LFDT_READ: if (i_bus_ack) state_next = LFDT_WRITE;
      LFDT_WRITE: if (i_bus_ack) state_next = keep_bus ? LFDT_ARB : LFDT_IDLE;
    endcase
  end

  // bus strobes are registered; the write follows the read ack directly
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_reg <= LFDT_IDLE;
      cur_reg <= 1'b0;
      hold_reg <= '0;
      o_bus_req <= 1'b0;
      o_bus <= '0;
    end else begin
      state_reg <= state_next;
      unique case (state_reg)
        LFDT_IDLE: o_bus_req <= any_elig;
        LFDT_ARB: begin
          o_bus_req <= any_elig;
          if (any_elig && i_bus_grant) begin
            cur_reg <= pick1;
            o_bus.rd <= 1'b1;
            o_bus.addr <= ch_setup[pick1].src;
            o_bus.be <= lfdt_lane(ch_setup[pick1].src[0], ch_setup[pick1].cfg.byte_mode);
          end
        end
        LFDT_READ: if (i_bus_ack) begin
          hold_reg <= cur_setup.cfg.byte_mode ? {rd_byte, rd_byte} : i_bus_rdata;
          o_bus.rd <= 1'b0;
          o_bus.wr <= 1'b1;
          o_bus.addr <= cur_setup.dst;
          o_bus.be <= lfdt_lane(cur_setup.dst[0], cur_setup.cfg.byte_mode);
          o_bus.wdata <= cur_setup.cfg.byte_mode ? {rd_byte, rd_byte} : i_bus_rdata;
        end
        LFDT_WRITE: if (i_bus_ack) begin
          o_bus.wr <= 1'b0;
          o_bus.be <= `LFDT_BE_NONE;
          o_bus_req <= keep_bus;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // port receive interrupts: sticky pending, lowest index served first
  localparam int IW = $clog2(NPORT);
  function automatic logic [IW-1:0] first_set(input logic [NPORT-1:0] v);
    logic [IW-1:0] r;
    r = '0;
    for (int k = NPORT - 1; k >= 0; k--) begin
      if (v[k]) r = IW'(k);
    end
    return r;
  endfunction

  logic [NPORT-1:0] pend_reg;
  logic [NPORT-1:0] pend_next;
  logic [NPORT-1:0] clr_mask;
  assign clr_mask = (i_irq_ack && o_irq_req) ? (NPORT'(1) << o_irq_id) : '0;
  // a new receive in the acknowledge cycle wins over the clear
  assign pend_next = (pend_reg & ~clr_mask) | i_port_rx;

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pend_reg <= '0;
      o_irq_req <= 1'b0;
      o_irq_id <= '0;
    end else begin
      pend_reg <= pend_next;
      o_irq_req <= |pend_next;
      o_irq_id <= first_set(pend_next);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  property p_wr_follows;
    @(posedge i_core_clk) disable iff (!i_rstn)
      (state_reg == LFDT_READ && i_bus_ack) |=>
        (o_bus.wr && !o_bus.rd && o_bus.addr == cur_setup.dst && o_bus.wdata == hold_reg);
  endproperty
  a_wr_follows: assert property (p_wr_follows) else $error("write not next after read");

  property p_hold_stable;
    @(posedge i_core_clk) disable iff (!i_rstn)
      (state_reg == LFDT_WRITE && $past(state_reg) == LFDT_WRITE) |-> $stable(hold_reg);
  endproperty
  a_hold_stable: assert property (p_hold_stable) else $error("held data changed");

  property p_wr_after_rd;
    @(posedge i_core_clk) disable iff (!i_rstn)
      $rose(o_bus.wr) |-> $past(state_reg) == LFDT_READ && $past(o_bus.rd);
  endproperty
  a_wr_after_rd: assert property (p_wr_after_rd) else $error("write without read");

  property p_one_owner;
    @(posedge i_core_clk) disable iff (!i_rstn)
      (state_reg == LFDT_READ) |-> ##1 (cur_reg == $past(cur_reg)) && !(o_bus.rd && o_bus.wr);
  endproperty
  a_one_owner: assert property (p_one_owner) else $error("channel changed mid pair");

  property p_abort;
    @(posedge i_core_clk) disable iff (!i_rstn)
      (standalone && i_cpu_sys_ref) |=> o_cpu_abort;
  endproperty
  a_abort: assert property (p_abort) else $error("system reference not aborted");

  property p_isolate;
    @(posedge i_core_clk) disable iff (!i_rstn)
      standalone [*2] |-> !o_xcvr_en && !o_bp_local_hit;
  endproperty
  a_isolate: assert property (p_isolate) else $error("backplane not isolated");

  property p_rx_irq;
    @(posedge i_core_clk) disable iff (!i_rstn)
      (|i_port_rx) |=> o_irq_req && pend_reg != '0;
  endproperty
  a_rx_irq: assert property (p_rx_irq) else $error("receive raised no request");

  property p_irq_prio;
    @(posedge i_core_clk) disable iff (!i_rstn)
      o_irq_req |-> pend_reg[o_irq_id] && ((pend_reg & ((NPORT'(1) << o_irq_id) - 1'b1)) == '0);
  endproperty
  a_irq_prio: assert property (p_irq_prio) else $error("lower port passed over");

  property p_byte_lane;
    @(posedge i_core_clk) disable iff (!i_rstn)
      (o_bus.rd && cur_setup.cfg.byte_mode) |-> o_bus.be != `LFDT_BE_WORD;
  endproperty
  a_byte_lane: assert property (p_byte_lane) else $error("byte access on both lanes");

  c_burst: cover property (@(posedge i_core_clk) disable iff (!i_rstn)
    state_reg == LFDT_WRITE && i_bus_ack && keep_bus);
  c_byte: cover property (@(posedge i_core_clk) disable iff (!i_rstn)
    o_bus.wr && o_bus.be == `LFDT_BE_HI);
  c_abort: cover property (@(posedge i_core_clk) disable iff (!i_rstn) o_cpu_abort);
  c_both: cover property (@(posedge i_core_clk) disable iff (!i_rstn) elig == 2'h3);
endmodule

//--- testbench/lfdt_mem.sv
// local bus partner: arbiter grant, byte-lane memory, ack after a set wait
// assumes rd/wr held until ack and one cycle per request
`timescale 1ns/1ps
module lfdt_mem
  import lfdt_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic i_bus_req,
  input wire lfdt_bus_type i_bus,
  input wire logic [3:0] i_wait,
  output logic o_grant,
  output logic o_ack,
  output logic [`LFDT_DATA_W-1:0] o_rdata
);
  logic [7:0] store [0:65535];
  logic [3:0] wait_reg;
  logic [15:0] wa;
  // word accesses land on the even address, lanes pick the bytes
  assign wa = {i_bus.addr[15:1], 1'b0};
  ////////////////////////////////////////////////////////////////////////
  // ack pulse after i_wait idle cycles; rdata toggles when not valid,
  // so a design that samples it at the wrong edge gets garbage
  always @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_grant <= 1'b0;
      o_ack <= 1'b0;
      wait_reg <= 4'h0;
      o_rdata <= 16'hA5A5;
    end else begin
      o_grant <= i_bus_req; // grant follows request one cycle late
      o_rdata <= ~o_rdata;
      if (o_ack) begin
        o_ack <= 1'b0;
        wait_reg <= 4'h0;
      end else if (i_bus.rd || i_bus.wr) begin
        if (wait_reg == i_wait) begin
          o_ack <= 1'b1;
          if (i_bus.rd) o_rdata <= {store[wa+16'h0001], store[wa]};
          if (i_bus.wr && i_bus.be[0]) store[wa] <= i_bus.wdata[7:0];
          if (i_bus.wr && i_bus.be[1]) store[wa+16'h0001] <= i_bus.wdata[15:8];
        end else begin
          wait_reg <= wait_reg + 4'h1;
        end
      end
    end
  end
endmodule

//--- testbench/tb_top.sv
// self-checking bench for the two-channel transfer engine
// assumes lfdt_mem as bus partner; the bench plays the local processor
`timescale 1ns/1ps
module tb_top
  import lfdt_pkg::*;
;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic id_sw = 1'b0;
  logic pri = 1'b0;
  logic cpu_ref = 1'b0;
  logic bp_sel = 1'b0;
  logic irq_ack = 1'b0;
  logic [1:0] start = 2'b00;
  logic [2:0] dreq = 3'b000;
  logic [3:0] rx = 4'h0;
  logic [3:0] wt = 4'h0;
  lfdt_setup_type s0 = '0;
  lfdt_setup_type s1 = '0;
  logic grant, ack, bus_req, abort, hit, xen, irq, rd_ack_d;
  logic [15:0] rdata;
  lfdt_bus_type bus;
  logic [1:0] busy, done, irq_id;
  int error_cnt = 0;
  int n_checks = 0;
  int cycles = 0;
  int rds = 0;
  always #4 clk = ~clk;
  lfdt_top #(.NPORT(4)) dut (.i_core_clk(clk), .i_rstn(rstn), .i_id_switch(id_sw),
    .i_start(start), .i_setup0(s0), .i_setup1(s1), .i_pri_ch1(pri), .i_port_dreq(dreq),
    .i_bus_grant(grant), .i_bus_ack(ack), .i_bus_rdata(rdata), .o_bus_req(bus_req),
    .o_bus(bus), .o_busy(busy), .o_done(done), .i_cpu_sys_ref(cpu_ref),
    .o_cpu_abort(abort), .i_bp_sel(bp_sel), .o_bp_local_hit(hit), .o_xcvr_en(xen),
    .i_port_rx(rx), .i_irq_ack(irq_ack), .o_irq_req(irq), .o_irq_id(irq_id));
  lfdt_mem bus_mem (.i_core_clk(clk), .i_rstn(rstn), .i_bus_req(bus_req), .i_bus(bus),
    .i_wait(wt), .o_grant(grant), .o_ack(ack), .o_rdata(rdata));
  ////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask
  // inputs always move 1 ns after the rising edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic go(input logic [1:0] c);
    start = c;
    cyc(1);
    start = 2'b00;
    cyc(1); // let an edge pass so back-to-back starts never merge
  endtask
  task automatic wait_idle;
    for (int i = 0; i < 400 && busy !== 2'b00; i++) cyc(1);
    chk(busy === 2'b00, "channel stays busy");
  endtask
  // fill n bytes from a base value and compare n bytes of a copy
  task automatic fill(input logic [15:0] a, input logic [7:0] v, input int n);
    for (int i = 0; i < n; i++) bus_mem.store[a+16'(i)] = v + 8'(i);
  endtask
  task automatic same(input logic [15:0] s, input logic [15:0] d, input int n);
    for (int i = 0; i < n; i++) chk(bus_mem.store[d+16'(i)] === bus_mem.store[s+16'(i)], "copy");
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_mode;
    chk(xen === 1'b0, "transceivers on");
    bp_sel = 1'b1;
    cpu_ref = 1'b1;
    cyc(1);
    cpu_ref = 1'b0;
    chk(abort === 1'b1, "system reference not aborted");
    cyc(3);
    chk(hit === 1'b0, "backplane select seen");
    id_sw = 1'b1;
    cyc(4);
    chk(xen === 1'b1 && hit === 1'b1, "peripheral mode");
    cpu_ref = 1'b1;
    cyc(1);
    cpu_ref = 1'b0;
    chk(abort === 1'b0, "abort outside standalone");
    id_sw = 1'b0;
    bp_sel = 1'b0;
    cyc(4);
    chk(xen === 1'b0, "back to standalone");
    $display("test mode done");
  endtask
  task automatic t_word;
    int i;
    fill(16'h0100, 8'h30, 10);
    fill(16'h0300, 8'h00, 1);
    bus_mem.store[16'h0308] = 8'h00;
    s0 = {16'h0100, 16'h0300, 16'h0004, 6'b011100};
    go(2'b01);
    chk(busy === 2'b01, "start not taken");
    s0 = {16'h0101, 16'h0301, 16'h0001, 6'b011100};
    go(2'b01); // start while busy must be ignored
    for (i = 0; i < 200 && done[0] !== 1'b1; i++) cyc(1);
    chk(done === 2'b01 && busy === 2'b00, "no done");
    cyc(1);
    chk(done === 2'b00, "done too long");
    same(16'h0100, 16'h0300, 8);
    chk(bus_mem.store[16'h0308] === 8'h00, "copied past count");
    $display("test word done");
  endtask
  task automatic t_byte;
    wt = 4'h2; // slow partner
    fill(16'h0401, 8'h11, 3);
    bus_mem.store[16'h0503] = 8'hEE;
    dreq = 3'b001; // serial port A paces this channel
    s1 = {16'h0401, 16'h0500, 16'h0003, 6'b101101};
    go(2'b10);
    wait_idle();
    same(16'h0401, 16'h0500, 3);
    chk(bus_mem.store[16'h0503] === 8'hEE, "extra byte");
    wt = 4'h0;
    dreq = 3'b000;
    $display("test byte done");
  endtask
  task automatic t_tie;
    fill(16'h0600, 8'h60, 4);
    fill(16'hFF00, 8'hC0, 4);
    pri = 1'b1;
    s0 = {16'h0600, 16'h0700, 16'h0002, 6'b011100};
    s1 = {16'hFF00, 16'h0800, 16'h0002, 6'b011100};
    go(2'b11);
    for (int i = 0; i < 50 && bus.rd !== 1'b1; i++) cyc(1);
    chk(bus.addr === 16'hFF00, "priority");
    wait_idle();
    same(16'h0600, 16'h0700, 4);
    same(16'hFF00, 16'h0800, 4);
    pri = 1'b0;
    $display("test tie done");
  endtask
  task automatic t_pace;
    s0 = {16'h0600, 16'h0A00, 16'h0002, 6'b011111};
    rds = 0;
    go(2'b01);
    cyc(30);
    chk(rds == 0 && busy === 2'b01, "ran without request");
    chk(bus_req === 1'b0, "bus requested without pacing");
    dreq = 3'b100;
    wait_idle();
    same(16'h0600, 16'h0A00, 4);
    dreq = 3'b000;
    $display("test pace done");
  endtask
  // reset lands while the first read is outstanding; engine must come back idle
  task automatic t_reset;
    s0 = {16'h0600, 16'h0B00, 16'h0002, 6'b011100};
    go(2'b01);
    cyc(3);
    rstn = 1'b0;
    cyc(1);
    chk(busy === 2'b00 && bus_req === 1'b0, "reset left busy");
    chk(bus.rd === 1'b0 && bus.wr === 1'b0, "reset left strobe");
    cyc(2);
    rstn = 1'b1;
    cyc(1);
    chk(busy === 2'b00 && bus.rd === 1'b0, "false start after reset");
    chk(xen === 1'b0, "transceivers on after reset");
    $display("test reset done");
  endtask
  task automatic t_irq;
    rx = 4'b1010;
    cyc(1);
    rx = 4'h0;
    chk(irq === 1'b1 && irq_id === 2'h1, "first request");
    irq_ack = 1'b1;
    cyc(1);
    irq_ack = 1'b0;
    chk(irq === 1'b1 && irq_id === 2'h3, "second request");
    irq_ack = 1'b1;
    cyc(1);
    irq_ack = 1'b0;
    chk(irq === 1'b0, "request left");
    $display("test irq done");
  endtask
  ////////////////////////////////////////////////////////////////////////
  // bus monitor: write follows read ack at once; timeout guard
  always @(posedge clk) begin
    cycles++;
    if (rd_ack_d === 1'b1) chk(bus.wr === 1'b1, "write not next cycle");
    rd_ack_d <= (bus.rd === 1'b1) && (ack === 1'b1);
    if (bus.rd === 1'b1 && ack === 1'b1) rds++;
    if (cycles == 20000) begin
      chk(1'b0, "timeout");
      end_sim();
    end
  end
  initial begin
    cyc(3);
    rstn = 1'b1;
    cyc(1);
    t_mode();
    t_word();
    t_byte();
    t_tie();
    t_pace();
    t_reset();
    t_irq();
    end_sim();
  end
endmodule
